// *** verilog/eeec_top.sv ***
// eeec_top: enclave entry, exit, asynchronous exit and resume sequencer
// assumes: operations arrive from the core on I_CLK; registers via AXI4-Lite
// Summary of operation
// - entry takes entry location and save-frame pointer from the given thread structure
// - a structure is busy from entry until exit; entering a busy one faults
// - several thread structures each keep their own busy bit
// - entry first checks busy, then flushes cached address translations
// - entry sets enclave mode, then saves stack and frame pointers
// - entry saves extended control register and loads the feature mask
// - debug enclave with debug asked allows traps; otherwise one instruction
// - entry marks the structure busy, then jumps to its entry location
// - exit takes an outside target and returns the async exit pointer
// - exit clears mode and flushes, frees structure, then jumps outside
// - exit leaves general registers untouched; software scrubs secrets
// - exit event saves state to save frame, shows synthetic state
// - most exit events push the async exit pointer as return address
// - after asynchronous exit the processor is outside enclave mode
// - resume restores saved state and continues at the interrupted point; here it jumps to the structure entry location
// - 32-bit resume reloads low halves of eight registers, pointer, flags
// - 64-bit resume reloads sixteen full registers, pointer, flags
// - resume restores masked features, x87 layout chosen by long mode
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module eeec_top #(
  parameter int NTCS = 8,
  parameter int AW   = 64
) (
  // clock, reset, enable
  input  wire logic                    I_CLK,
  input  wire logic                    I_NRST,
  input  wire logic                    I_CE,
  // operation request from core
  input  wire logic                    I_OP_VALID,
  input  wire logic [1:0]              I_OP_CODE,
  input  wire logic [$clog2(NTCS)-1:0] I_OP_TCS,
  input  wire logic [AW-1:0]           I_OP_ADDR,
  input  wire logic [AW-1:0]           I_TCS_ENTRY,
  input  wire logic [AW-1:0]           I_TCS_FRAME,
  input  wire logic [AW-1:0]           I_SP,
  input  wire logic [AW-1:0]           I_FP,
  input  wire logic                    I_EVT_PUSH,
  // operation results
  output logic                         O_OP_DONE,
  output logic                         O_OP_FAULT,
  output logic                         O_ENCL_MODE,
  output logic                         O_TLB_FLUSH,
  output logic                         O_JUMP,
  output logic [AW-1:0]                O_JUMP_ADDR,
  output logic [AW-1:0]                O_RET_VAL,
  output logic [AW-1:0]                O_SAVE_SP,
  output logic [AW-1:0]                O_SAVE_FP,
  output logic [AW-1:0]                O_FRAME_PTR,
  output logic                         O_STATE_SAVE,
  output logic                         O_SYNTH,
  output logic                         O_PUSH_EXIT,
  output logic                         O_RESTORE,
  output logic [4:0]                   O_RESTORE_NREG,
  output logic                         O_RESTORE_WIDE,
  output logic                         O_SINGLE_STEP,
  output logic [31:0]                  O_XCTL,
  // AXI4-Lite slave
  input  wire logic [7:0]              S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output logic                         S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output logic                         S_AXI_WREADY,
  output logic [1:0]                   S_AXI_BRESP,
  output logic                         S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  input  wire logic [7:0]              S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output logic                         S_AXI_ARREADY,
  output logic [31:0]                  S_AXI_RDATA,
  output logic [1:0]                   S_AXI_RRESP,
  output logic                         S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY
);
  localparam int TW = $clog2(NTCS);

  // byte-lane merge
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : wmerge

  // state
  eeec_pkg::eeec_state_t st_reg;
  logic [1:0]     op_reg;
  logic [TW-1:0]  tcs_reg;
  logic [AW-1:0]  addr_reg, entry_reg, frame_reg;
  logic [NTCS-1:0] busy_reg;
  logic [TW-1:0]  cur_tcs_reg;
  logic [AW-1:0]  exitptr_reg;
  logic [31:0]    ctrl_reg, xmask_reg, xctl_reg, savedx_reg, faults_reg;
  logic           push_reg;

  // register bus state
  logic [7:0]  awaddr_reg;
  logic        aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_have_reg;

  // decode of the current request
  wire logic        start      = I_CE && I_OP_VALID && !O_OP_DONE && st_reg == eeec_pkg::ST_IDLE;
  wire logic        tgt_busy   = busy_reg[tcs_reg];
  wire logic        long_mode  = ctrl_reg[eeec_pkg::CTRL_LMA] && ctrl_reg[eeec_pkg::CTRL_CSL];
  wire logic        dbg_on     = ctrl_reg[eeec_pkg::CTRL_DBG_EN]
                                 && ctrl_reg[eeec_pkg::CTRL_DBG_ENCL];
  wire logic        is_enter   = (op_reg == eeec_pkg::OP_ENTER);
  wire logic        is_exit    = (op_reg == eeec_pkg::OP_EXIT);
  wire logic        is_resume  = (op_reg == eeec_pkg::OP_RESUME);
  wire logic        is_event   = (op_reg == eeec_pkg::OP_EVENT);
  // exit-type ops are only legal inside enclave mode; resume/enter only outside
  wire logic        bad_mode   = (is_exit || is_event) ? !O_ENCL_MODE : O_ENCL_MODE;

  // register write path
  wire logic        wr_fire   = aw_have_reg && w_have_reg && !S_AXI_BVALID;
  wire logic        wr_ctrl   = wr_fire && (awaddr_reg == eeec_pkg::OFF_CTRL);
  wire logic        wr_xmask  = wr_fire && (awaddr_reg == eeec_pkg::OFF_XMASK);
  wire logic        wr_faults = wr_fire && (awaddr_reg == eeec_pkg::OFF_FAULTS);
  wire logic        wr_ok     = wr_ctrl || wr_xmask || wr_faults;

  // register read decode
  logic [31:0] rd_data;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = eeec_pkg::RST_ZERO;
    if (S_AXI_ARADDR == eeec_pkg::OFF_CTRL) begin
      rd_data = ctrl_reg;
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_STATUS) begin
      rd_data = {24'h000000, st_reg == eeec_pkg::ST_IDLE, O_ENCL_MODE, 6'(cur_tcs_reg)};
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_BUSY) begin
      rd_data = 32'(busy_reg);
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_XMASK) begin
      rd_data = xmask_reg;
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_XCTL) begin
      rd_data = xctl_reg;
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_SAVEDX) begin
      rd_data = savedx_reg;
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_EXITPTR) begin
      rd_data = exitptr_reg[31:0];
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_TARGET) begin
      rd_data = entry_reg[31:0];
    end else if (S_AXI_ARADDR == eeec_pkg::OFF_FAULTS) begin
      rd_data = faults_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= eeec_pkg::RST_ZERO;
      wstrb_reg     <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= eeec_pkg::RESP_OKAY;
    end else if (I_CE) begin
      S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_have_reg && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= {S_AXI_AWADDR[7:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? eeec_pkg::RESP_OKAY : eeec_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= eeec_pkg::RST_ZERO;
      S_AXI_RRESP   <= eeec_pkg::RESP_OKAY;
    end else if (I_CE) begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && !S_AXI_ARVALID ? 1'b1 :
                       (!S_AXI_RVALID && !S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_data;
        S_AXI_RRESP   <= rd_ok ? eeec_pkg::RESP_OKAY : eeec_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_reg   <= eeec_pkg::RST_ZERO;
      xmask_reg  <= eeec_pkg::RST_XCTL;
      faults_reg <= eeec_pkg::RST_ZERO;
    end else if (I_CE) begin
      if (wr_ctrl) ctrl_reg <= wmerge(ctrl_reg, wdata_reg, wstrb_reg);
      if (wr_xmask) xmask_reg <= wmerge(xmask_reg, wdata_reg, wstrb_reg);
      // fault count: hardware increment wins over a software clear
      if (st_reg == eeec_pkg::ST_CHECK && (bad_mode || (is_enter && tgt_busy)))
        faults_reg <= faults_reg + 32'h0000_0001;
      else if (wr_faults)
        faults_reg <= eeec_pkg::RST_ZERO;
    end
  end

  // operation sequencer
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_reg         <= eeec_pkg::ST_IDLE;
      op_reg         <= eeec_pkg::OP_ENTER;
      tcs_reg        <= '0;
      cur_tcs_reg    <= '0;
      addr_reg       <= '0;
      entry_reg      <= '0;
      frame_reg      <= '0;
      busy_reg       <= '0;
      exitptr_reg    <= '0;
      xctl_reg       <= eeec_pkg::RST_XCTL;
      savedx_reg     <= eeec_pkg::RST_ZERO;
      push_reg       <= 1'b0;
      O_OP_DONE      <= 1'b0;
      O_OP_FAULT     <= 1'b0;
      O_ENCL_MODE    <= 1'b0;
      O_TLB_FLUSH    <= 1'b0;
      O_JUMP         <= 1'b0;
      O_JUMP_ADDR    <= '0;
      O_RET_VAL      <= '0;
      O_SAVE_SP      <= '0;
      O_SAVE_FP      <= '0;
      O_FRAME_PTR    <= '0;
      O_STATE_SAVE   <= 1'b0;
      O_SYNTH        <= 1'b0;
      O_PUSH_EXIT    <= 1'b0;
      O_RESTORE      <= 1'b0;
      O_RESTORE_NREG <= 5'h00;
      O_RESTORE_WIDE <= 1'b0;
      O_SINGLE_STEP  <= 1'b0;
      O_XCTL         <= eeec_pkg::RST_XCTL;
    end else if (I_CE) begin
      O_OP_DONE    <= 1'b0;
      O_OP_FAULT   <= 1'b0;
      O_TLB_FLUSH  <= 1'b0;
      O_JUMP       <= 1'b0;
      O_STATE_SAVE <= 1'b0;
      O_SYNTH      <= 1'b0;
      O_PUSH_EXIT  <= 1'b0;
      O_RESTORE    <= 1'b0;
      O_XCTL       <= xctl_reg;
      case (st_reg)
        eeec_pkg::ST_IDLE: begin
          if (start) begin
            op_reg    <= I_OP_CODE;
            tcs_reg   <= (I_OP_CODE == eeec_pkg::OP_ENTER ||
                          I_OP_CODE == eeec_pkg::OP_RESUME) ? I_OP_TCS : cur_tcs_reg;
            addr_reg  <= I_OP_ADDR;
            entry_reg <= I_TCS_ENTRY;
            frame_reg <= I_TCS_FRAME;
            push_reg  <= I_EVT_PUSH;
            st_reg    <= eeec_pkg::ST_CHECK;
          end
        end
        eeec_pkg::ST_CHECK: begin
          // busy test comes before any other effect; one sequencer makes it atomic
          if (bad_mode || ((is_enter || is_resume) && tgt_busy)) begin
            O_OP_FAULT <= 1'b1;
            O_OP_DONE  <= 1'b1;
            st_reg     <= eeec_pkg::ST_IDLE;
          end else if (is_event) begin
            O_STATE_SAVE <= 1'b1;
            O_FRAME_PTR  <= frame_reg;
            st_reg       <= eeec_pkg::ST_SAVE;
          end else if (is_exit) begin
            O_ENCL_MODE <= 1'b0;
            O_TLB_FLUSH <= 1'b1;
            st_reg      <= eeec_pkg::ST_CLEAR;
          end else begin
            O_TLB_FLUSH <= 1'b1;
            st_reg      <= eeec_pkg::ST_MODE;
          end
        end
        eeec_pkg::ST_MODE: begin
          O_ENCL_MODE <= 1'b1;
          cur_tcs_reg <= tcs_reg;
          if (is_enter) exitptr_reg <= addr_reg;
          st_reg <= eeec_pkg::ST_SAVE;
        end
        eeec_pkg::ST_SAVE: begin
          if (is_event) begin
            // synthetic state, exit pointer as return address, leave enclave
            O_SYNTH     <= 1'b1;
            O_PUSH_EXIT <= push_reg;
            O_RET_VAL   <= exitptr_reg;
            O_ENCL_MODE <= 1'b0;
            xctl_reg    <= savedx_reg;
            st_reg      <= eeec_pkg::ST_XFER;
          end else if (is_resume) begin
            O_RESTORE      <= 1'b1;
            O_FRAME_PTR    <= frame_reg;
            O_RESTORE_NREG <= long_mode ? eeec_pkg::NREG_64 : eeec_pkg::NREG_32;
            O_RESTORE_WIDE <= long_mode;
            savedx_reg     <= xctl_reg;
            xctl_reg       <= xmask_reg;
            O_SINGLE_STEP  <= dbg_on;
            st_reg         <= eeec_pkg::ST_MARK;
          end else begin
            O_SAVE_SP     <= I_SP;
            O_SAVE_FP     <= I_FP;
            savedx_reg    <= xctl_reg;
            xctl_reg      <= xmask_reg;
            O_SINGLE_STEP <= dbg_on;
            st_reg        <= eeec_pkg::ST_MARK;
          end
        end
        eeec_pkg::ST_MARK: begin
          busy_reg[tcs_reg] <= 1'b1;
          st_reg <= eeec_pkg::ST_XFER;
        end
        eeec_pkg::ST_CLEAR: begin
          busy_reg[tcs_reg] <= 1'b0;
          xctl_reg  <= savedx_reg;
          O_RET_VAL <= exitptr_reg;
          st_reg    <= eeec_pkg::ST_XFER;
        end
        eeec_pkg::ST_XFER: begin
          if (is_event) begin
            busy_reg[tcs_reg] <= 1'b0;
          end else begin
            O_JUMP      <= 1'b1;
            // enter and resume jump to the structure entry location, exit outside
            O_JUMP_ADDR <= is_exit ? addr_reg : entry_reg;
          end
          O_OP_DONE <= 1'b1;
          st_reg    <= eeec_pkg::ST_IDLE;
        end
        default: st_reg <= eeec_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : eeec_top

// *** pkg/eeec_pkg.sv ***
// eeec_pkg: constants for the enclave entry/exit control block
// assumes: one 100 MHz clock, AXI4-Lite register access, 32-bit data
package eeec_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_BUSY    = 8'h08;
  localparam logic [7:0] OFF_XMASK   = 8'h0C;
  localparam logic [7:0] OFF_XCTL    = 8'h10;
  localparam logic [7:0] OFF_SAVEDX  = 8'h14;
  localparam logic [7:0] OFF_EXITPTR = 8'h18;
  localparam logic [7:0] OFF_TARGET  = 8'h1C;
  localparam logic [7:0] OFF_FAULTS  = 8'h20;
  // control field positions
  localparam int CTRL_DBG_EN   = 0;
  localparam int CTRL_DBG_ENCL = 1;
  localparam int CTRL_LMA      = 2;
  localparam int CTRL_CSL      = 3;
  // reset values
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
  localparam logic [31:0] RST_XCTL  = 32'h0000_0003;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // operation codes
  localparam logic [1:0]  OP_ENTER  = 2'h0;
  localparam logic [1:0]  OP_EXIT   = 2'h1;
  localparam logic [1:0]  OP_RESUME = 2'h2;
  localparam logic [1:0]  OP_EVENT  = 2'h3;
  // restore widths
  localparam logic [4:0]  NREG_32 = 5'h08;
  localparam logic [4:0]  NREG_64 = 5'h10;
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CHECK = 7'h02,
    ST_MODE  = 7'h04,
    ST_SAVE  = 7'h08,
    ST_MARK  = 7'h10,
    ST_XFER  = 7'h20,
    ST_CLEAR = 7'h40
  } eeec_state_t;
endpackage : eeec_pkg

// *** tb/eeec_core_model.sv ***
// eeec_core_model: core side that issues enclave operations to the block
// assumes: same clock as eeec_top; one operation under way at a time
`timescale 1ns/1ps
module eeec_core_model (
  // clock
  input  wire logic        i_clk,
  // request to the block
  output logic             o_op_valid,
  output logic [1:0]       o_op_code,
  output logic [2:0]       o_op_tcs,
  output logic [63:0]      o_op_addr,
  output logic [63:0]      o_tcs_entry,
  output logic [63:0]      o_tcs_frame,
  output logic [63:0]      o_sp,
  output logic [63:0]      o_fp,
  output logic             o_evt_push,
  // answer from the block
  input  wire logic        i_done,
  input  wire logic        i_fault,
  input  wire logic [4:0]  i_pulses
);
  // idle values at time zero
  initial begin
    o_op_valid = 1'b0;
    o_op_code = 2'h0;
    o_op_tcs = 3'h0;
    o_op_addr = 64'h0;
    o_tcs_entry = 64'h0;
    o_tcs_frame = 64'h0;
    o_sp = 64'h0;
    o_fp = 64'h0;
    o_evt_push = 1'b0;
  end

  // request held until done; structure fields differ per structure index
  task automatic issue(input logic [1:0] c, input logic [2:0] t, input logic [63:0] a,
                       input logic e, output logic f, output logic [4:0] p, output logic to);
    int k;
    @(posedge i_clk);
    o_op_valid <= 1'b1;
    o_op_code <= c;
    o_op_tcs <= t;
    o_op_addr <= a;
    o_tcs_entry <= {32'h7000_0000, 29'h0, t};
    o_tcs_frame <= {32'h7100_0000, 29'h0, t};
    o_sp <= {32'h5000_0000, 29'h0, t};
    o_fp <= {32'h5100_0000, 29'h0, t};
    o_evt_push <= e;
    p = 5'h0;
    k = 0;
    do begin
      @(posedge i_clk);
      p = p | i_pulses;
      k++;
    end while (i_done !== 1'b1 && k < 40);
    f = i_fault;
    to = (k >= 40);
    // released: stale op address and entry lines show the inverse; frame, sp and fp keep the last value
    o_op_valid <= 1'b0;
    o_op_addr <= ~a;
    o_tcs_entry <= ~o_tcs_entry;
  endtask : issue
endmodule : eeec_core_model

// *** tb/eeec_top_sva.sv ***
// eeec_top_sva: port-level checks of the entry, exit and resume sequencing
// assumes: bound to eeec_top; request held until done
`timescale 1ns/1ps
module eeec_top_sva #(
  parameter int NTCS = 8,
  parameter int AW   = 64
) (
  input wire logic          I_CLK, I_NRST, I_OP_VALID, I_EVT_PUSH,
  input wire logic [1:0]    I_OP_CODE,
  input wire logic [AW-1:0] I_OP_ADDR, I_TCS_ENTRY, I_SP, I_FP,
  input wire logic          O_OP_DONE, O_OP_FAULT, O_ENCL_MODE, O_TLB_FLUSH, O_JUMP,
  input wire logic [AW-1:0] O_JUMP_ADDR, O_SAVE_SP, O_SAVE_FP,
  input wire logic          O_STATE_SAVE, O_SYNTH, O_PUSH_EXIT, O_RESTORE, O_RESTORE_WIDE,
  input wire logic [4:0]    O_RESTORE_NREG
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // request kinds that must be refused in the present mode
  wire is_ent = I_OP_VALID && I_OP_CODE == eeec_pkg::OP_ENTER;
  wire refuse = O_ENCL_MODE ? (I_OP_CODE == eeec_pkg::OP_ENTER || I_OP_CODE == eeec_pkg::OP_RESUME)
                            : (I_OP_CODE == eeec_pkg::OP_EXIT || I_OP_CODE == eeec_pkg::OP_EVENT);
  a_refuse_time: assert property ($rose(I_OP_VALID) && refuse |-> ##[2:3] (O_OP_FAULT && O_OP_DONE))
    else $error("refused request not faulted in time");
  a_fault_nojump: assert property (O_OP_FAULT |-> O_OP_DONE && !O_JUMP && !O_TLB_FLUSH)
    else $error("fault without done or with jump");
  a_enter_order: assert property ($rose(O_ENCL_MODE) && is_ent |-> $past(O_TLB_FLUSH)
      ##1 (O_SAVE_SP == I_SP && O_SAVE_FP == I_FP) ##2 (O_JUMP && O_OP_DONE))
    else $error("entry steps out of order");
  a_exit_order: assert property ($fell(O_ENCL_MODE) && I_OP_VALID && I_OP_CODE == eeec_pkg::OP_EXIT
      |-> O_TLB_FLUSH ##2 (O_JUMP && O_OP_DONE && O_JUMP_ADDR == I_OP_ADDR))
    else $error("exit steps out of order");
  a_event_synth: assert property (O_STATE_SAVE |=> (O_SYNTH && !O_ENCL_MODE
      && O_PUSH_EXIT == I_EVT_PUSH) ##1 (O_OP_DONE && !O_JUMP))
    else $error("exit event sequence wrong");
  a_jump_entry: assert property (O_JUMP && O_ENCL_MODE |-> O_JUMP_ADDR == I_TCS_ENTRY)
    else $error("jump inside not to structure entry");
  a_restore_width: assert property (O_OP_DONE && !O_OP_FAULT && I_OP_VALID
      && I_OP_CODE == eeec_pkg::OP_RESUME |-> O_RESTORE_NREG
      == (O_RESTORE_WIDE ? eeec_pkg::NREG_64 : eeec_pkg::NREG_32))
    else $error("restore count does not match width");
  a_mode_cause: assert property ($changed(O_ENCL_MODE) |-> $past(I_OP_VALID))
    else $error("enclave mode changed without request");
  // main scenarios reached
  c_enter: cover property ($rose(O_ENCL_MODE) && is_ent);
  c_event: cover property (O_STATE_SAVE && I_EVT_PUSH);
  c_refuse: cover property (O_OP_FAULT);
endmodule : eeec_top_sva

bind eeec_top eeec_top_sva #(.NTCS(NTCS), .AW(AW)) eeec_top_sva_i (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_OP_VALID(I_OP_VALID), .I_EVT_PUSH(I_EVT_PUSH),
  .I_OP_CODE(I_OP_CODE), .I_OP_ADDR(I_OP_ADDR), .I_TCS_ENTRY(I_TCS_ENTRY), .I_SP(I_SP),
  .I_FP(I_FP), .O_OP_DONE(O_OP_DONE), .O_OP_FAULT(O_OP_FAULT), .O_ENCL_MODE(O_ENCL_MODE),
  .O_TLB_FLUSH(O_TLB_FLUSH), .O_JUMP(O_JUMP), .O_JUMP_ADDR(O_JUMP_ADDR), .O_SAVE_SP(O_SAVE_SP),
  .O_SAVE_FP(O_SAVE_FP), .O_STATE_SAVE(O_STATE_SAVE), .O_SYNTH(O_SYNTH),
  .O_PUSH_EXIT(O_PUSH_EXIT), .O_RESTORE(O_RESTORE), .O_RESTORE_WIDE(O_RESTORE_WIDE),
  .O_RESTORE_NREG(O_RESTORE_NREG));

// *** tb/tb_enclave_entry_exit_control.sv ***
// tb_enclave_entry_exit_control: self-checking bench for eeec_top
// assumes: core model drives operations; bench is the register bus master
`timescale 1ns/1ps
module tb_enclave_entry_exit_control;
  logic        I_CLK, I_NRST, valid, evtp, done, fault, mode, tflush, jump, ssave, synth;
  logic        push, rest, wide, sstep, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0]  code, bresp, rresp;
  logic [2:0]  thread_control_struct;
  logic [4:0]  nreg;
  logic [7:0]  awaddr, araddr;
  logic [31:0] xctl, wdata, rdata;
  logic [63:0] addr, entry, frame, sp, fp, jaddr, retv, ssp, sfp, fptr;
  int          errors, n_checks;

  eeec_top eeec_top_i (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(1'b1), .I_OP_VALID(valid), .I_OP_CODE(code),
    .I_OP_TCS(thread_control_struct), .I_OP_ADDR(addr), .I_TCS_ENTRY(entry), .I_TCS_FRAME(frame), .I_SP(sp),
    .I_FP(fp), .I_EVT_PUSH(evtp), .O_OP_DONE(done), .O_OP_FAULT(fault), .O_ENCL_MODE(mode),
    .O_TLB_FLUSH(tflush), .O_JUMP(jump), .O_JUMP_ADDR(jaddr), .O_RET_VAL(retv),
    .O_SAVE_SP(ssp), .O_SAVE_FP(sfp), .O_FRAME_PTR(fptr), .O_STATE_SAVE(ssave),
    .O_SYNTH(synth), .O_PUSH_EXIT(push), .O_RESTORE(rest), .O_RESTORE_NREG(nreg),
    .O_RESTORE_WIDE(wide), .O_SINGLE_STEP(sstep), .O_XCTL(xctl), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
  eeec_core_model eeec_core_model_i (
    .i_clk(I_CLK), .o_op_valid(valid), .o_op_code(code), .o_op_tcs(thread_control_struct), .o_op_addr(addr),
    .o_tcs_entry(entry), .o_tcs_frame(frame), .o_sp(sp), .o_fp(fp), .o_evt_push(evtp),
    .i_done(done), .i_fault(fault), .i_pulses({push, synth, ssave, rest, tflush}));

  // 100 MHz clock
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // register write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge I_CLK);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge I_CLK);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        r = bresp;
        br <= 1'b0;
        k = 99;
      end
    end
    if (k == 50) chk("bvalid", 1'b1, 1'b0);
    if (k == 50) end_sim();
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge I_CLK);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge I_CLK);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        d = rdata;
        r = rresp;
        rr <= 1'b0;
        k = 99;
      end
    end
    if (k == 50) chk("rvalid", 1'b1, 1'b0);
    if (k == 50) end_sim();
  endtask : axr

  task automatic op(input logic [1:0] c, input logic [2:0] t, input logic [63:0] a,
                    input logic e, output logic f, output logic [4:0] p);
    logic to;
    eeec_core_model_i.issue(c, t, a, e, f, p, to);
    if (to) chk("op_done", 1'b1, 1'b0);
    if (to) end_sim();
  endtask : op

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axr(eeec_pkg::OFF_XCTL, d, r);
    chk("xctl_rst", eeec_pkg::RST_XCTL, d);
    axw(8'h40, 32'hFFFF_FFFF, r);
    chk("wr_unmapped", eeec_pkg::RESP_SLVERR, r);
    axr(8'h40, d, r);
    chk("rd_unmapped", eeec_pkg::RESP_SLVERR, r);
    axw(eeec_pkg::OFF_XMASK, 32'h0000_0007, r);
    axr(eeec_pkg::OFF_XMASK, d, r);
    chk("xmask_wr", 32'h0000_0007, d);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_enter_exit();
    logic        f;
    logic [4:0]  p;
    logic [31:0] d;
    logic [1:0]  r;
    op(eeec_pkg::OP_ENTER, 3'h1, 64'hA000_0000_0000_00A1, 1'b0, f, p);
    chk("enter_flush", 2'h1, {f, p[0]});
    chk("save_fp", {32'h5100_0000, 32'h1}, sfp);
    chk("xctl_out", 32'h0000_0007, xctl);
    axr(eeec_pkg::OFF_SAVEDX, d, r);
    chk("xctl_saved", eeec_pkg::RST_XCTL, d);
    axr(eeec_pkg::OFF_BUSY, d, r);
    chk("busy_set", 32'h0000_0002, d);
    op(eeec_pkg::OP_ENTER, 3'h1, 64'h0, 1'b0, f, p);
    chk("reenter_fault", 1'b1, f);
    op(eeec_pkg::OP_EXIT, 3'h1, 64'h0000_0000_0000_0B00, 1'b0, f, p);
    chk("exit_ret", 64'hA000_0000_0000_00A1, retv);
    chk("exit_jump", 64'h0B00, {mode, jaddr[62:0]});
    axr(eeec_pkg::OFF_BUSY, d, r);
    chk("busy_clr", 32'h0, d);
    op(eeec_pkg::OP_EXIT, 3'h1, 64'h0, 1'b0, f, p);
    chk("exit_out_fault", 1'b1, f);
    axr(eeec_pkg::OFF_FAULTS, d, r);
    chk("fault_cnt", 32'h2, d);
    $display("t_enter_exit done");
  endtask : t_enter_exit

  task automatic t_debug();
    logic       f;
    logic [4:0] p;
    logic [1:0] r;
    for (int i = 0; i < 3; i++) begin
      axw(eeec_pkg::OFF_CTRL, 32'h3 >> i, r);
      op(eeec_pkg::OP_ENTER, 3'h2, 64'h0, 1'b0, f, p);
      chk("single_step", i == 0, sstep);
      op(eeec_pkg::OP_EXIT, 3'h2, 64'h0, 1'b0, f, p);
    end
    $display("t_debug done");
  endtask : t_debug

  task automatic t_evt_resume();
    logic       f;
    logic [4:0] p;
    logic [1:0] r;
    logic [2:0] t;
    for (int i = 0; i < 2; i++) begin
      t = 3'h4 + 3'(i);
      axw(eeec_pkg::OFF_CTRL, i ? 32'h4 : 32'hC, r);
      op(eeec_pkg::OP_ENTER, t, 64'hAE, 1'b0, f, p);
      op(eeec_pkg::OP_EVENT, t, 64'h0, 1'b1, f, p);
      chk("evt_pulses", 6'h1C, {mode, p & 5'h1C});
      chk("evt_frame", {32'h7100_0000, 29'h0, t}, fptr);
      chk("evt_ret", 64'hAE, retv);
      op(eeec_pkg::OP_RESUME, t, 64'h0, 1'b0, f, p);
      chk("res_restore", 2'h3, {mode, p[1]});
      chk("res_nreg", i ? eeec_pkg::NREG_32 : eeec_pkg::NREG_64, nreg);
      chk("res_wide", i == 0, wide);
      chk("res_jump", {32'h7000_0000, 29'h0, t}, jaddr);
      op(eeec_pkg::OP_EVENT, t, 64'h0, 1'b0, f, p);
      chk("evt_nopush", 1'b0, p[4]);
    end
    op(eeec_pkg::OP_EVENT, 3'h4, 64'h0, 1'b1, f, p);
    chk("evt_out_fault", 1'b1, f);
    $display("t_evt_resume done");
  endtask : t_evt_resume

  // reset, then the scenarios in turn
  initial begin
    I_NRST = 1'b0;
    {awv, wv, br, arv, rr} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    repeat (10) @(posedge I_CLK);
    I_NRST <= 1'b1;
    t_regs();
    t_enter_exit();
    t_debug();
    t_evt_resume();
    end_sim();
  end
endmodule : tb_enclave_entry_exit_control
